//--- casp_defs.svh
// offsets, field positions, reset values and timing counts for the serial port
`ifndef CASP_DEFS_SVH
`define CASP_DEFS_SVH

`define CASP_WORD_W        16
`define CASP_NUM_REGS      8
`define CASP_REG_RESET     8'h00

`define CASP_OFF_SERIAL    3'h0
`define CASP_OFF_CLOCK     3'h1
`define CASP_OFF_REFPWR    3'h2
`define CASP_OFF_GAIN1     3'h3
`define CASP_OFF_GAIN2     3'h4
`define CASP_OFF_GAIN3     3'h5
`define CASP_OFF_CHAN1     3'h6
`define CASP_OFF_CHAN2     3'h7

`define CASP_BIT_CTRL      15
`define CASP_BIT_READ      14
`define CASP_DEV_HI        13
`define CASP_DEV_LO        11
`define CASP_REG_HI        10
`define CASP_REG_LO        8
`define CASP_DAT_HI        7

`define CASP_A_SAMPLE_SEL  0
`define CASP_A_MIXED       1
`define CASP_A_SOFT_RESET  7
`define CASP_B_DR_LO       0
`define CASP_B_SCD_LO      2
`define CASP_B_MCD_LO      4

`define CASP_FULL_SCALE    16'h7fff
`define CASP_CLK_NS        100
`define CASP_HALF_BASE     4
`define CASP_SAMPLE_BASE   256

`endif

//--- casp_pkg.sv
// shared types of the cascadable sample serial link
package casp_pkg;
  typedef logic [15:0] casp_word_t;
  typedef logic [7:0]  casp_byte_t;
  typedef enum logic [0:0] {CASP_TX_IDLE, CASP_TX_SEND} casp_tx_e;
endpackage : casp_pkg

//--- casp_clk_div.sv
// master clock divider and serial clock generator
`timescale 1ns/1ps
`include "casp_defs.svh"
module casp_clk_div import casp_pkg::*; #(
  parameter int HALF_BASE = `CASP_HALF_BASE
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] mcd,
  input  wire logic [1:0] scd,
  output logic            dm_tick_q,
  output logic            sclk_q,
  output logic            rise_q,
  output logic            fall_q
);
  generate
    if (HALF_BASE < 2 || HALF_BASE > 16) begin : g_bad
      $error("casp_clk_div: HALF_BASE out of range");
    end
  endgenerate

  logic [2:0] mc_q;
  logic [7:0] hc_q;
  logic [7:0] half_len;

  // codes above the five valid dividers fall back to divide by one
  function automatic logic [2:0] casp_mdiv_last(input logic [2:0] code);
    casp_mdiv_last = (code > 3'h4) ? 3'h0 : code;
  endfunction : casp_mdiv_last

  assign half_len = 8'(HALF_BASE) << scd;

  always_ff @(posedge ref_clk or negedge rst_b) begin // [RULE_09]
    if (!rst_b) begin
      mc_q      <= 3'h0;
      dm_tick_q <= 1'b0;
    end else if (mc_q >= casp_mdiv_last(mcd)) begin
      mc_q      <= 3'h0;
      dm_tick_q <= 1'b1;
    end else begin
      mc_q      <= mc_q + 3'h1;
      dm_tick_q <= 1'b0;
    end
  end

  // serial clock half period is HALF_BASE internal ticks times 1,2,4,8
  always_ff @(posedge ref_clk or negedge rst_b) begin // [RULE_10]
    if (!rst_b) begin
      hc_q   <= 8'h00;
      sclk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (dm_tick_q) begin
        if (hc_q >= half_len - 8'h01) begin
          hc_q   <= 8'h00;
          sclk_q <= !sclk_q;
          rise_q <= !sclk_q;
          fall_q <= sclk_q;
        end else begin
          hc_q <= hc_q + 8'h01;
        end
      end
    end
  end
endmodule : casp_clk_div

//--- casp_ctl_regs.sv
// eight 8-bit control registers with software reset
`timescale 1ns/1ps
`include "casp_defs.svh"
module casp_ctl_regs import casp_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_addr,
  input  wire casp_byte_t wr_data,
  output logic [63:0]     regs_q
);
  logic soft_rst;

  // the reset bit never sticks: a write that sets it clears every register
  assign soft_rst = wr_en && (wr_addr == `CASP_OFF_SERIAL)
                    && wr_data[`CASP_A_SOFT_RESET];

  always_ff @(posedge ref_clk or negedge rst_b) begin // [RULE_11]
    if (!rst_b) begin
      regs_q <= {`CASP_NUM_REGS{`CASP_REG_RESET}};
    end else if (soft_rst) begin
      regs_q <= {`CASP_NUM_REGS{`CASP_REG_RESET}};
    end else if (wr_en) begin
      regs_q[wr_addr*8 +: 8] <= wr_data;
    end
  end
endmodule : casp_ctl_regs

//--- casp_serial_port.sv
// serial port and control word interpreter of the sampling front end
// Operation
// RULE_01: up to eight devices chained to one host
// RULE_02: program mode reads and writes control registers
// RULE_03: data mode ignores input, sends samples only
// RULE_04: mixed mode: msb flags control or sample
// RULE_05: one 16-bit register shifts both directions
// RULE_06: sample event overwrites the shift register
// RULE_07: host writes after sample shifting begins
// RULE_08: serial rate bounds words per sample interval
// RULE_09: master clock divided by one to five
// RULE_10: serial clock is internal clock over 1,2,4,8
// RULE_11: eight 8-bit registers, reset to zero
// RULE_12: host programs first two registers identically everywhere
// RULE_13: registers update on serial clock falling edge
// RULE_14: control word field layout fixed
// RULE_15: msb high marks control, low invalid
// RULE_16: write when read bit low, address zero
// RULE_17: read copies register into outgoing word
// RULE_18: nonzero address decremented and forwarded
// RULE_19: both directions msb first at serial rate
// RULE_20: device is master, starts every frame
// RULE_21: 16-bit samples left shifted, clamp 0x7fff
// RULE_22: decode only after all sixteen bits
`timescale 1ns/1ps
`include "casp_defs.svh"
module casp_serial_port import casp_pkg::*; #(
  parameter int SAMPLE_BASE = `CASP_SAMPLE_BASE,
  parameter int HALF_BASE   = `CASP_HALF_BASE
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        sdi,
  input  wire logic        sdifs,
  input  wire logic [14:0] adc_sample,
  input  wire logic        adc_over,
  output logic             sclk,
  output logic             sdo,
  output logic             sdofs,
  output logic [47:0]      analog_ctrl
);
  generate
    if (SAMPLE_BASE < 32 || SAMPLE_BASE > 512) begin : g_bad
      $error("casp_serial_port: SAMPLE_BASE out of range");
    end
  endgenerate

  logic        dm_tick;
  logic        rise;
  logic        fall;
  logic [63:0] regs;
  logic [7:0]  reg_serial;
  logic [7:0]  reg_clock;
  logic        sample_sel;
  logic        mixed_traffic_enable;
  logic        rx_allowed;
  logic        sdi_m_q;
  logic        sdi_s_q;
  logic        sdifs_m_q;
  logic        sdifs_s_q;
  casp_word_t  shift_q;
  casp_word_t  rx_word;
  casp_word_t  sample_word;
  logic        rx_act_q;
  logic [3:0]  rx_cnt_q;
  logic        rx_bit;
  logic        last_fall;
  logic        is_ctrl;
  logic        addr_zero;
  logic        wr_en;
  logic        rd_hit;
  logic        fwd_hit;
  casp_tx_e    tx_st_q;
  logic [3:0]  tx_cnt_q;
  logic        start_tx;
  logic        send_req_q;
  logic [11:0] smp_cnt_q;
  logic        smp_evt_q;
  logic        sclk_int;

  assign reg_serial           = regs[7:0];
  assign reg_clock            = regs[15:8];
  assign sample_sel           = reg_serial[`CASP_A_SAMPLE_SEL];
  assign mixed_traffic_enable = reg_serial[`CASP_A_MIXED];
  // only pure sample mode shuts the input side
  assign rx_allowed = !sample_sel || mixed_traffic_enable; // [RULE_03]

  function automatic casp_byte_t casp_pick(input logic [63:0] r,
                                           input logic [2:0]  a);
    casp_pick = r[a*8 +: 8];
  endfunction : casp_pick

  // sample interval: base ticks times 8,4,2,1 by decimation code
  function automatic logic [11:0] casp_smp_len(input logic [1:0] dr);
    casp_smp_len = 12'(SAMPLE_BASE) << (2'h3 - dr);
  endfunction : casp_smp_len

  casp_clk_div #(
    .HALF_BASE (HALF_BASE)
  ) u_clk (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .mcd       (reg_clock[`CASP_B_MCD_LO +: 3]),
    .scd       (reg_clock[`CASP_B_SCD_LO +: 2]),
    .dm_tick_q (dm_tick),
    .sclk_q    (sclk_int),
    .rise_q    (rise),
    .fall_q    (fall)
  );

  casp_ctl_regs u_regs (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (wr_en),
    .wr_addr (rx_word[`CASP_REG_HI:`CASP_REG_LO]),
    .wr_data (rx_word[`CASP_DAT_HI:0]),
    .regs_q  (regs)
  );

  // serial pin inputs sdi and sdifs cross in through two flops before any use
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdi_m_q   <= 1'b0;
      sdi_s_q   <= 1'b0;
      sdifs_m_q <= 1'b0;
      sdifs_s_q <= 1'b0;
    end else begin
      sdi_m_q   <= sdi;
      sdi_s_q   <= sdi_m_q;
      sdifs_m_q <= sdifs;
      sdifs_s_q <= sdifs_m_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk        <= 1'b0;
      analog_ctrl <= 48'h0;
    end else begin
      sclk        <= sclk_int;
      analog_ctrl <= regs[63:16];
    end
  end

  // mixed mode gives up the lsb so the msb can carry the data flag
  always_comb begin // [RULE_21] [RULE_04]
    if (mixed_traffic_enable) begin
      sample_word = adc_over ? `CASP_FULL_SCALE : {1'b0, adc_sample};
    end else begin
      sample_word = adc_over ? `CASP_FULL_SCALE : {adc_sample, 1'b0};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin // [RULE_08]
    if (!rst_b) begin
      smp_cnt_q <= 12'h000;
      smp_evt_q <= 1'b0;
    end else begin
      smp_evt_q <= 1'b0;
      if (dm_tick) begin
        if (smp_cnt_q >= casp_smp_len(reg_clock[`CASP_B_DR_LO +: 2])
                         - 12'h001) begin
          smp_cnt_q <= 12'h000;
          smp_evt_q <= 1'b1;
        end else begin
          smp_cnt_q <= smp_cnt_q + 12'h001;
        end
      end
    end
  end

  // receive framing: the incoming frame sync marks the first bit
  assign rx_bit    = fall && rx_allowed && (rx_act_q || sdifs_s_q);
  assign rx_word   = {shift_q[14:0], sdi_s_q};
  assign last_fall = fall && rx_allowed && rx_act_q
                     && (rx_cnt_q == 4'hf); // [RULE_22]
  assign is_ctrl   = rx_word[`CASP_BIT_CTRL]; // [RULE_15]
  assign addr_zero = rx_word[`CASP_DEV_HI:`CASP_DEV_LO] == 3'h0; // [RULE_14]
  assign wr_en     = last_fall && is_ctrl && addr_zero
                     && !rx_word[`CASP_BIT_READ]; // [RULE_16] [RULE_13]
  assign rd_hit    = last_fall && is_ctrl && addr_zero
                     && rx_word[`CASP_BIT_READ]; // [RULE_17] [RULE_02]
  assign fwd_hit   = last_fall && is_ctrl && !addr_zero; // [RULE_18] [RULE_01]

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 4'h0;
    end else if (last_fall) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 4'h0;
    end else if (rx_bit) begin
      rx_act_q <= 1'b1;
      rx_cnt_q <= rx_cnt_q + 4'h1;
    end
  end

  // one register serves both directions; a sample event wins over all
  always_ff @(posedge ref_clk or negedge rst_b) begin // [RULE_05]
    if (!rst_b) begin
      shift_q <= 16'h0000;
    end else if (smp_evt_q) begin
      shift_q <= sample_word; // [RULE_06]
    end else if (rd_hit) begin
      shift_q <= {rx_word[15:8],
                  casp_pick(regs, rx_word[`CASP_REG_HI:`CASP_REG_LO])};
    end else if (fwd_hit) begin
      shift_q <= {rx_word[15:14],
                  rx_word[`CASP_DEV_HI:`CASP_DEV_LO] - 3'h1,
                  rx_word[10:0]};
    end else if (fall && (rx_bit || tx_st_q == CASP_TX_SEND)) begin
      shift_q <= rx_word; // [RULE_19]
    end
  end

  // a reply or forward raised while a frame is out goes in the next one
  always_ff @(posedge ref_clk or negedge rst_b) begin // [RULE_20]
    if (!rst_b) begin
      send_req_q <= 1'b0;
    end else if (smp_evt_q || rd_hit || fwd_hit) begin
      send_req_q <= 1'b1;
    end else if (start_tx) begin
      send_req_q <= 1'b0;
    end
  end

  assign start_tx = rise && send_req_q && (tx_st_q == CASP_TX_IDLE);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q  <= CASP_TX_IDLE;
      tx_cnt_q <= 4'h0;
      sdo      <= 1'b0;
      sdofs    <= 1'b0;
    end else begin
      case (tx_st_q)
        CASP_TX_IDLE: begin
          if (start_tx) begin
            tx_st_q  <= CASP_TX_SEND;
            tx_cnt_q <= 4'h0;
            sdo      <= shift_q[15];
            sdofs    <= 1'b1;
          end
        end
        CASP_TX_SEND: begin
          if (rise) begin
            sdo   <= shift_q[15]; // [RULE_19]
            sdofs <= 1'b0;
          end
          if (fall) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == 4'hf) begin
              tx_st_q <= CASP_TX_IDLE;
            end
          end
        end
        default: begin
          tx_st_q <= CASP_TX_IDLE;
        end
      endcase
    end
  end

  sequence s_frame_open;
    start_tx ##1 (sdofs && tx_st_q == CASP_TX_SEND);
  endsequence

  sequence s_first_bit;
    rise ##1 (sdofs == 1'b0);
  endsequence

  a_sample_only_mode: assert property ( // [RULE_03]
    @(posedge ref_clk) disable iff (!rst_b)
    (sample_sel && !mixed_traffic_enable) |-> !wr_en && !rd_hit)
    else $error("control word taken in sample-only mode");

  a_write_on_fall: assert property ( // [RULE_13]
    @(posedge ref_clk) disable iff (!rst_b)
    wr_en |-> fall && !sclk_int)
    else $error("register write off the falling edge");

  a_write_lands: assert property ( // [RULE_16]
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_en && rx_word[10:8] != `CASP_OFF_SERIAL) |=>
      casp_pick(regs, $past(rx_word[10:8])) == $past(rx_word[7:0]))
    else $error("written byte not in selected register");

  a_invalid_word: assert property ( // [RULE_15]
    @(posedge ref_clk) disable iff (!rst_b)
    (last_fall && !rx_word[15]) |-> !wr_en && !rd_hit && !fwd_hit)
    else $error("word with low msb acted upon");

  a_sample_load: assert property ( // [RULE_06]
    @(posedge ref_clk) disable iff (!rst_b)
    smp_evt_q |=> shift_q == $past(sample_word))
    else $error("sample not loaded at sample event");

  a_clamp_full: assert property ( // [RULE_21]
    @(posedge ref_clk) disable iff (!rst_b)
    (smp_evt_q && adc_over) |=> shift_q == `CASP_FULL_SCALE)
    else $error("over-range sample not clamped");

  a_forward_dec: assert property ( // [RULE_18]
    @(posedge ref_clk) disable iff (!rst_b)
    (fwd_hit && !smp_evt_q) |=>
      shift_q[13:11] == $past(rx_word[13:11]) - 3'h1 ##0 send_req_q)
    else $error("forwarded address not decremented");

  a_read_copy: assert property ( // [RULE_17]
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_hit && !smp_evt_q) |=>
      shift_q[7:0] == casp_pick($past(regs), $past(rx_word[10:8])))
    else $error("read data not placed in outgoing word");

  a_frame_open: assert property ( // [RULE_20]
    @(posedge ref_clk) disable iff (!rst_b)
    start_tx |-> s_frame_open)
    else $error("frame did not open with sync");

  a_sync_one_bit: assert property ( // [RULE_19]
    @(posedge ref_clk) disable iff (!rst_b)
    (sdofs && rise) |-> s_first_bit)
    else $error("frame sync held past first bit");
endmodule : casp_serial_port

//--- casp_host_model.sv
// host serial port model: sends queued words, logs every device frame
`timescale 1ns/1ps
module casp_host_model (
  input  wire logic ref_clk,
  input  wire logic sclk,
  input  wire logic sdo,
  input  wire logic sdofs,
  output logic      sdi,
  output logic      sdifs
);
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  logic [15:0] sh = 16'h0000;
  logic [15:0] rx = 16'h0000;
  logic [15:0] w;
  logic        prev = 1'b0;
  int          nb = 0;
  int          rb = -1;
  int          cnt = 0;
  int          half = 0;
  initial sdi = 1'b0;
  initial sdifs = 1'b0;

  always @(posedge ref_clk) begin
    prev <= sclk;
    cnt <= cnt + 1;
    if (sclk != prev) begin
      half <= cnt;
      cnt <= 1;
    end
    if (sclk && !prev && nb > 0) begin
      sdi <= sh[15];
      sh <= sh << 1;
    end else if (sclk && !prev && sdofs && tx_q.size() > 0) begin
      // only inside a device frame, so words never meet a sample
      w = tx_q.pop_front();
      sdi <= w[15];
      sdifs <= 1'b1;
      sh <= {w[14:0], 1'b0};
      nb <= 16;
    end else if (nb == 0) begin
      // released line keeps moving so a stale bit never looks valid
      sdi <= ~sdi;
    end
    if (sclk && !prev && sdofs)
      rb <= 0;
    if (!sclk && prev) begin
      sdifs <= 1'b0;
      if (nb > 0)
        nb <= nb - 1;
      if (rb >= 0) begin
        rx <= {rx[14:0], sdo};
        rb <= (rb == 15) ? -1 : rb + 1;
        if (rb == 15)
          rx_q.push_back({rx[14:0], sdo});
      end
    end
  end
endmodule : casp_host_model

//--- casp_serial_port_test.sv
// bench for the serial port: host model traffic against a register model
`timescale 1ns/1ps
module casp_serial_port_test import casp_pkg::*; ;
  localparam int SB = 512;
  localparam int HB = 4;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sdi;
  logic        sdifs;
  logic        sclk;
  logic        sdo;
  logic        sdofs;
  logic [14:0] adc_sample = 15'h0000;
  logic        adc_over = 1'b0;
  logic [47:0] analog_ctrl;
  logic [7:0]  regs[8] = '{default: 8'h00};
  logic        mixed = 1'b0;
  logic        datam = 1'b0;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // divider settings; decimation keeps each frame well inside a sample
  int          mt[6] = '{0, 1, 2, 3, 4, 5};
  int          st[6] = '{3, 2, 1, 0, 0, 0};
  int          dt[6] = '{1, 2, 3, 3, 3, 3};

  casp_serial_port #(.SAMPLE_BASE(SB), .HALF_BASE(HB)) u_casp_serial_port (
    .ref_clk(ref_clk), .rst_b(rst_b), .sdi(sdi), .sdifs(sdifs),
    .adc_sample(adc_sample), .adc_over(adc_over), .sclk(sclk), .sdo(sdo),
    .sdofs(sdofs), .analog_ctrl(analog_ctrl));
  casp_host_model u_casp_host_model (
    .ref_clk(ref_clk), .sclk(sclk), .sdo(sdo), .sdofs(sdofs), .sdi(sdi),
    .sdifs(sdifs));

  initial forever #50 ref_clk = ~ref_clk;

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic casp_word_t smp();
    if (adc_over)
      return 16'h7fff;
    return mixed ? {1'b0, adc_sample} : {adc_sample, 1'b0};
  endfunction : smp

  function automatic logic [47:0] ctrl_exp();
    logic [47:0] v;
    for (int i = 2; i < 8; i++)
      v[(i-2)*8 +: 8] = regs[i];
    return v;
  endfunction : ctrl_exp

  task automatic wait_rx(input int k);
    int n;
    n = u_casp_host_model.rx_q.size() + k;
    while (u_casp_host_model.rx_q.size() < n)
      @(posedge ref_clk);
  endtask : wait_rx

  // w rides on a frame holding a fresh sample; the next frame is checked too
  task automatic xfer(input casp_word_t w);
    casp_word_t a_exp;
    casp_word_t b_exp;
    logic       on;
    @(posedge ref_clk);
    adc_sample <= 15'($urandom);
    adc_over <= ($urandom_range(0, 5) == 0);
    wait_rx(1);
    a_exp = smp();
    on = w[15] && !(datam && !mixed);
    u_casp_host_model.tx_q.push_back(w);
    if (on && w[13:11] == 3'h0 && !w[14]) begin
      regs[w[10:8]] = w[7:0];
      // the reset bit wipes every register, itself included
      if (w[10:8] == 3'h0 && w[7])
        regs = '{default: 8'h00};
      if (w[10:8] == 3'h0)
        {mixed, datam} = regs[0][1:0];
    end
    b_exp = smp();
    if (on && w[13:11] != 3'h0)
      b_exp = {w[15:14], w[13:11] - 3'h1, w[10:0]};
    if (on && w[13:11] == 3'h0 && w[14])
      b_exp = {w[15:8], regs[w[10:8]]};
    wait_rx(2);
    chk(48'(u_casp_host_model.rx_q[$-1]), 48'(a_exp));
    chk(48'(u_casp_host_model.rx_q[$]), 48'(b_exp));
    chk(analog_ctrl, ctrl_exp());
  endtask : xfer

  initial begin
    void'($urandom(32'h9c6b6310));
    repeat (4) @(posedge ref_clk);
    chk(analog_ctrl, 48'h0);
    rst_b <= 1'b1;
    xfer(16'h8103);
    for (int a = 2; a < 8; a++)
      xfer({5'b10000, 3'(a), 8'($urandom)});
    repeat (4) xfer({5'b11000, 3'($urandom), 8'h00});
    repeat (2) xfer({1'b1, 1'($urandom), 3'($urandom_range(1, 7)),
                     11'($urandom)});
    xfer({1'b0, 15'($urandom)});
    for (int i = 0; i < 6; i++) begin
      xfer({8'h81, 1'b0, 3'(mt[i]), 2'(st[i]), 2'(dt[i])});
      // divider codes above the five valid ones fall back to divide by one
      chk(48'(u_casp_host_model.half),
          48'((HB << st[i]) * (mt[i] > 4 ? 1 : mt[i] + 1)));
    end
    xfer(16'h8080);
    xfer(16'h8103);
    xfer(16'h8003);
    xfer({8'h86, 8'($urandom)});
    xfer(16'hc600);
    xfer(16'h8001);
    xfer({8'h85, 8'($urandom)});
    xfer(16'hc300);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({45'h0, sclk, sdo, sdofs}, 48'h0);
    chk(analog_ctrl, 48'h0);
    stop_test();
  end
endmodule : casp_serial_port_test
